/* File: shared/status_integrity_pkg.sv */
// Constants, field layout and state types of the status and integrity register group
`default_nettype none
package status_integrity_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_DEVICE_STATUS = 8'h14;
    localparam logic [7:0] ADDR_TICK_COUNT    = 8'h15;
    localparam logic [7:0] ADDR_OFFSET_CORR_X = 8'h16;
    localparam logic [7:0] ADDR_OFFSET_CORR_Y = 8'h17;
    localparam logic [7:0] ADDR_RESERVED_A    = 8'h1c;
    localparam logic [7:0] ADDR_RESERVED_B    = 8'h1d;

    // Device status bit positions; bits 5 and 7 are unused
    localparam int BIT_RESET_OCCURRED = 0;
    localparam int BIT_OFFSET_X       = 1;
    localparam int BIT_OFFSET_Y       = 2;
    localparam int BIT_MISO_MISMATCH  = 3;
    localparam int BIT_INIT_PROGRESS  = 4;
    localparam int BIT_DATA_ERROR     = 6;

    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [9:0] PRESCALE_RESET = 10'h000;

    // Tick prescaler: 10 bits, divide by 1024
    localparam int         PRESCALE_WIDTH = 10;
    localparam int         PRESCALE_DIV   = 1024;
    localparam logic [9:0] PRESCALE_LAST  = 10'(PRESCALE_DIV - 1);
    localparam logic [7:0] TICK_STEP      = 8'h01;

    // 3-bit check over x^3 + x + 1, seed 111
    localparam logic [2:0] CRC_SEED = 3'h7;
    localparam logic [2:0] CRC_POLY = 3'h3;
    localparam int         CRC_BYTES = 8;
    localparam int         ARRAY_BITS = CRC_BYTES * 8;

    // Internal initialisation length in clock cycles
    localparam logic [7:0] INIT_CYCLES = 8'h40;
    localparam logic [7:0] INIT_STEP   = 8'h01;

    typedef enum logic [1:0]
    {
        PH_RESET,
        PH_INIT,
        PH_RUN,
        PH_HELD
    } phase_e;

    typedef struct packed
    {
        phase_e     phase;
        logic [7:0] init_cnt;
        logic [9:0] prescale;
        logic [7:0] tick;
        logic [7:0] corr_x;
        logic [7:0] corr_y;
        logic       data_error;
        logic       init_flag;
        logic       miso_flag;
        logic       offx_flag;
        logic       offy_flag;
        logic       reset_flag;
        logic       wr_fault;
        logic       fault_resp;
        logic [7:0] rd_data;
        logic       rd_valid;
        logic       in_reset;
    } state_s;

endpackage : status_integrity_pkg
`default_nettype wire

/* File: hdl/status_integrity_registers.sv */
// Device status, tick counter, offset correction readback, array checks and supply-driven reset
`default_nettype none
module status_integrity_registers
(
    input  wire logic        clock_in,
    input  wire logic        resetn_in,
    input  wire logic        supply_ok_in,
    input  wire logic        cap_fail_in,
    input  wire logic        cap_fail_hold_in,
    input  wire logic        reg_rd_in,
    input  wire logic        reg_wr_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        miso_mismatch_in,
    input  wire logic        offset_limit_x_in,
    input  wire logic        offset_limit_y_in,
    input  wire logic        other_fault_in,
    input  wire logic        corr_valid_x_in,
    input  wire logic        corr_valid_y_in,
    input  wire logic [7:0]  corr_x_in,
    input  wire logic [7:0]  corr_y_in,
    input  wire logic [63:0] otp_array_in,
    input  wire logic [2:0]  otp_crc_in,
    input  wire logic [63:0] writable_array_in,
    input  wire logic [2:0]  writable_crc_in,
    input  wire logic        end_of_init_bit_in,
    output logic [7:0]       rd_data_out,
    output logic             rd_valid_out,
    output logic             in_reset_out,
    output logic             fault_response_out,
    output logic             write_lock_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Check function

    // Serial 3-bit CRC, bytes in ascending order, each byte MSB first
    function automatic logic [2:0] crc3(input logic [63:0] arr);
        logic [2:0] c;
        logic       fb;
        c = status_integrity_pkg::CRC_SEED;
        fb = 1'b0;
        for (int i = 0; i < status_integrity_pkg::CRC_BYTES; i++)
        begin
            for (int b = 7; b >= 0; b--)
            begin
                fb = c[2] ^ arr[i * 8 + b];
                c = {c[1:0], 1'b0} ^ (fb ? status_integrity_pkg::CRC_POLY : 3'h0);
            end
        end
        return c;
    endfunction : crc3

    ////////////////////////////////////////////////////////////////////////////
    // State

    status_integrity_pkg::state_s st_r;
    status_integrity_pkg::state_s st_nxt;
    logic                         lock_r;

    logic otp_bad;
    logic wr_bad;
    logic status_read;
    logic active;

    // Continuous recompute of both checks
    assign otp_bad     = crc3(otp_array_in) != otp_crc_in;
    assign wr_bad      = crc3(writable_array_in) != writable_crc_in;
    assign active      = (st_r.phase == status_integrity_pkg::PH_INIT) || (st_r.phase == status_integrity_pkg::PH_RUN);
    assign status_read = reg_rd_in && active && (reg_addr_in == status_integrity_pkg::ADDR_DEVICE_STATUS);

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    // Set always wins over the read-clear so an event in the read cycle survives
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rd_valid = 1'b0;
        st_nxt.in_reset = 1'b0;
        // Prescaler and tick counter run in every phase, but a bad supply outside the held phase freezes them
        st_nxt.prescale = st_r.prescale + 10'(1);
        if (st_r.prescale == status_integrity_pkg::PRESCALE_LAST)
        begin
            st_nxt.prescale = status_integrity_pkg::PRESCALE_RESET;
            st_nxt.tick = st_r.tick + status_integrity_pkg::TICK_STEP;
        end
        case (st_r.phase)
            status_integrity_pkg::PH_RESET:
            begin
                st_nxt.in_reset = 1'b1;
                if (supply_ok_in)
                begin
                    st_nxt.phase = status_integrity_pkg::PH_INIT;
                    st_nxt.init_cnt = status_integrity_pkg::RESET_BYTE;
                    st_nxt.init_flag = 1'b1;
                    st_nxt.reset_flag = 1'b1;
                    st_nxt.in_reset = 1'b0;
                end
            end
            status_integrity_pkg::PH_INIT:
            begin
                st_nxt.reset_flag = 1'b1;
                st_nxt.init_cnt = st_r.init_cnt + status_integrity_pkg::INIT_STEP;
                if (st_nxt.init_cnt == status_integrity_pkg::INIT_CYCLES)
                begin
                    st_nxt.phase = status_integrity_pkg::PH_RUN;
                    st_nxt.init_flag = 1'b0;
                end
            end
            status_integrity_pkg::PH_RUN:
            begin
                st_nxt.init_flag = 1'b0;
            end
            default:
            begin
                // Held after a capacitor failure; only the external reset leaves this
                st_nxt.in_reset = 1'b1;
            end
        endcase
        if (active)
        begin
            // Read returns the flags as they stand, then clears the transient ones
            if (status_read)
            begin
                st_nxt.data_error = 1'b0;
                st_nxt.miso_flag = 1'b0;
                st_nxt.offx_flag = 1'b0;
                st_nxt.offy_flag = 1'b0;
                if (st_r.phase == status_integrity_pkg::PH_RUN)
                begin
                    st_nxt.reset_flag = 1'b0;
                end
            end
            if (end_of_init_bit_in && wr_bad)
            begin
                st_nxt.wr_fault = 1'b1;
            end
            if (otp_bad || st_r.wr_fault || other_fault_in)
            begin
                st_nxt.data_error = 1'b1;
            end
            if (miso_mismatch_in)
            begin
                st_nxt.miso_flag = 1'b1;
            end
            if (offset_limit_x_in)
            begin
                st_nxt.offx_flag = 1'b1;
            end
            if (offset_limit_y_in)
            begin
                st_nxt.offy_flag = 1'b1;
            end
            if (corr_valid_x_in)
            begin
                st_nxt.corr_x = corr_x_in;
            end
            if (corr_valid_y_in)
            begin
                st_nxt.corr_y = corr_y_in;
            end
            if (cap_fail_in && cap_fail_hold_in)
            begin
                // Report reset from the first held cycle, not one cycle late
                st_nxt.phase = status_integrity_pkg::PH_HELD;
                st_nxt.in_reset = 1'b1;
            end
            else if (cap_fail_in)
            begin
                st_nxt.reset_flag = 1'b1;
                st_nxt.fault_resp = 1'b1;
            end
            // Register read port; reserved and unmapped addresses read as zero
            if (reg_rd_in)
            begin
                st_nxt.rd_valid = 1'b1;
                st_nxt.rd_data = status_integrity_pkg::RESET_BYTE;
                if (reg_addr_in == status_integrity_pkg::ADDR_DEVICE_STATUS)
                begin
                    st_nxt.rd_data[status_integrity_pkg::BIT_RESET_OCCURRED] = st_r.reset_flag;
                    st_nxt.rd_data[status_integrity_pkg::BIT_OFFSET_X] = st_r.offx_flag;
                    st_nxt.rd_data[status_integrity_pkg::BIT_OFFSET_Y] = st_r.offy_flag;
                    st_nxt.rd_data[status_integrity_pkg::BIT_MISO_MISMATCH] = st_r.miso_flag;
                    st_nxt.rd_data[status_integrity_pkg::BIT_INIT_PROGRESS] = st_r.init_flag;
                    st_nxt.rd_data[status_integrity_pkg::BIT_DATA_ERROR] = st_r.data_error;
                end
                else if (reg_addr_in == status_integrity_pkg::ADDR_TICK_COUNT)
                begin
                    st_nxt.rd_data = st_r.tick;
                end
                else if (reg_addr_in == status_integrity_pkg::ADDR_OFFSET_CORR_X)
                begin
                    st_nxt.rd_data = st_r.corr_x;
                end
                else if (reg_addr_in == status_integrity_pkg::ADDR_OFFSET_CORR_Y)
                begin
                    st_nxt.rd_data = st_r.corr_y;
                end
            end
            // Writes here are dropped: the group is read-only and reserved bytes take zeros only
        end
        // Supply monitor overrides everything except the held phase; fuse check runs again after release
        if (!supply_ok_in && st_r.phase != status_integrity_pkg::PH_HELD)
        begin
            st_nxt = '0;
            st_nxt.prescale = st_r.prescale;
            st_nxt.tick = st_r.tick;
            st_nxt.phase = status_integrity_pkg::PH_RESET;
            st_nxt.in_reset = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    // State register; one asynchronous reset for the whole group
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            st_r <= '0;
            st_r.phase <= status_integrity_pkg::PH_RESET;
            st_r.in_reset <= 1'b1;
            lock_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            lock_r <= end_of_init_bit_in && active;
        end
    end

    // Outputs straight from flip-flops
    assign rd_data_out        = st_r.rd_data;
    assign rd_valid_out       = st_r.rd_valid;
    assign in_reset_out       = st_r.in_reset;
    assign fault_response_out = st_r.fault_resp;
    assign write_lock_out     = lock_r;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!resetn_in);

    sequence s_running_read;
        st_r.phase == status_integrity_pkg::PH_RUN && status_read;
    endsequence

    sequence s_release;
        st_r.phase == status_integrity_pkg::PH_RESET && supply_ok_in;
    endsequence

    property p_miso_clear;
        s_running_read ##0 (!miso_mismatch_in && !cap_fail_in && supply_ok_in) |=> !st_r.miso_flag;
    endproperty
    a_miso_clear: assert property (p_miso_clear) else $error("mismatch flag not cleared by read");

    property p_init_kept;
        (st_r.init_flag && status_read && supply_ok_in && !cap_fail_in)
            |=> st_r.init_flag || st_r.phase == status_integrity_pkg::PH_RUN;
    endproperty
    a_init_kept: assert property (p_init_kept) else $error("init flag cleared by a read");

    property p_tick_step;
        (st_r.prescale == status_integrity_pkg::PRESCALE_LAST)
            |=> st_r.tick == $past(st_r.tick) + status_integrity_pkg::TICK_STEP
                && st_r.prescale == status_integrity_pkg::PRESCALE_RESET;
    endproperty
    a_tick_step: assert property (p_tick_step) else $error("tick did not advance at prescaler wrap");

    property p_tick_hold;
        (st_r.prescale != status_integrity_pkg::PRESCALE_LAST) |=> st_r.tick == $past(st_r.tick);
    endproperty
    a_tick_hold: assert property (p_tick_hold) else $error("tick moved between prescaler wraps");

    property p_otp_error;
        (active && otp_bad && supply_ok_in) |=> st_r.data_error;
    endproperty
    a_otp_error: assert property (p_otp_error) else $error("fuse array mismatch did not set data error");

    property p_wr_fault;
        (active && wr_bad && end_of_init_bit_in && supply_ok_in)
            |=> st_r.wr_fault ##1 (st_r.data_error || !$past(supply_ok_in));
    endproperty
    a_wr_fault: assert property (p_wr_fault) else $error("writable array fault not latched");

    property p_wr_reassert;
        (st_r.wr_fault && active && supply_ok_in) |=> st_r.data_error;
    endproperty
    a_wr_reassert: assert property (p_wr_reassert) else $error("data error not reasserted");

    property p_supply_reset;
        (!supply_ok_in && st_r.phase != status_integrity_pkg::PH_HELD) |=> st_r.in_reset && !st_r.rd_valid;
    endproperty
    a_supply_reset: assert property (p_supply_reset) else $error("not held in reset on bad supply");

    property p_reset_flag;
        s_release |=> st_r.reset_flag && st_r.init_flag;
    endproperty
    a_reset_flag: assert property (p_reset_flag) else $error("reset flag not set after release");

    property p_corr_load;
        (active && corr_valid_x_in && supply_ok_in) |=> st_r.corr_x == $past(corr_x_in);
    endproperty
    a_corr_load: assert property (p_corr_load) else $error("offset correction not captured");

    property p_cap_hold;
        (active && cap_fail_in && cap_fail_hold_in && supply_ok_in) |=> in_reset_out [*2];
    endproperty
    a_cap_hold: assert property (p_cap_hold) else $error("capacitor failure did not hold reset");

    property p_read_answer;
        (reg_rd_in && active && supply_ok_in) |=> st_r.rd_valid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("accepted read gave no answer");

    property p_held_mute;
        (st_r.phase == status_integrity_pkg::PH_HELD) |=> st_r.in_reset && !st_r.rd_valid;
    endproperty
    a_held_mute: assert property (p_held_mute) else $error("held device answered or left reset");

endmodule : status_integrity_registers
`default_nettype wire

/* File: verif/status_host_model.sv */
// Host-side register reader that stands in for the serial master
`default_nettype none
module status_host_model
(
    input  wire logic       clock_in,
    input  wire logic       rd_valid_in,
    input  wire logic [7:0] rd_data_in,
    output logic            reg_rd_out,
    output logic            reg_wr_out,
    output logic [7:0]      reg_addr_out,
    output logic [7:0]      reg_wdata_out
);
    timeunit 1ns;
    timeprecision 100ps;
    time take_t;
    ////////////////////////////////////////////////////////////////////////////////
    // Idle bus from time zero so no device input floats
    initial
    begin
        {reg_rd_out, reg_wr_out, reg_addr_out, reg_wdata_out} = 18'h00000;
    end
    // One read pulse; the answer is only looked for on the next few edges
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        @(posedge clock_in);
        #1;
        {reg_rd_out, reg_addr_out} = {1'b1, addr};
        @(posedge clock_in);
        take_t = $time;
        #1;
        {reg_rd_out, reg_addr_out} = {1'b0, ~addr}; // Released address shows a changing pattern
        {ok, data} = 9'h000;
        repeat (3)
        begin
            if (!ok && rd_valid_in === 1'b1)
                {ok, data} = {1'b1, rd_data_in};
            @(posedge clock_in);
            #1;
        end
    endtask : read_reg
    // Writes carry zeros only, so reserved places are never disturbed
    task automatic write_zero(input logic [7:0] addr);
        @(posedge clock_in);
        #1;
        {reg_wr_out, reg_addr_out, reg_wdata_out} = {1'b1, addr, 8'h00};
        @(posedge clock_in);
        #1;
        {reg_wr_out, reg_addr_out, reg_wdata_out} = {1'b0, ~addr, 8'hff};
    endtask : write_zero
endmodule : status_host_model
`default_nettype wire

/* File: verif/status_integrity_registers_test.sv */
// Self-checking bench for the status and integrity register group
`default_nettype none
module status_integrity_registers_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [63:0] OTP_DATA = 64'h0123_4567_89ab_cdef;
    localparam logic [63:0] WR_DATA  = 64'hfedc_ba98_7654_3210;
    localparam logic [7:0]  ST       = status_integrity_pkg::ADDR_DEVICE_STATUS;
    localparam int          INIT_W   = int'(status_integrity_pkg::INIT_CYCLES) + 8;
    logic       clock_in, resetn_in, supply_ok, cap_fail, cap_hold, miso_mm, lim_x, lim_y, oth_fault;
    logic       cv_x, cv_y, eoi, reg_rd, reg_wr, rval, in_rst, fresp, lock;
    logic [7:0] cx, cy, addr, wdata, rdat;
    logic [2:0] otp_crc, wr_crc;
    int         n_errors = 0;
    int         compares = 0;
    int         cycles = 0;
    ////////////////////////////////////////////////////////////////////////////////
    status_integrity_registers DUT
    (
        .clock_in           (clock_in),
        .resetn_in          (resetn_in),
        .supply_ok_in       (supply_ok),
        .cap_fail_in        (cap_fail),
        .cap_fail_hold_in   (cap_hold),
        .reg_rd_in          (reg_rd),
        .reg_wr_in          (reg_wr),
        .reg_addr_in        (addr),
        .reg_wdata_in       (wdata),
        .miso_mismatch_in   (miso_mm),
        .offset_limit_x_in  (lim_x),
        .offset_limit_y_in  (lim_y),
        .other_fault_in     (oth_fault),
        .corr_valid_x_in    (cv_x),
        .corr_valid_y_in    (cv_y),
        .corr_x_in          (cx),
        .corr_y_in          (cy),
        .otp_array_in       (OTP_DATA),
        .otp_crc_in         (otp_crc),
        .writable_array_in  (WR_DATA),
        .writable_crc_in    (wr_crc),
        .end_of_init_bit_in (eoi),
        .rd_data_out        (rdat),
        .rd_valid_out       (rval),
        .in_reset_out       (in_rst),
        .fault_response_out (fresp),
        .write_lock_out     (lock)
    );
    status_host_model host
    (
        .clock_in      (clock_in),
        .rd_valid_in   (rval),
        .rd_data_in    (rdat),
        .reg_rd_out    (reg_rd),
        .reg_wr_out    (reg_wr),
        .reg_addr_out  (addr),
        .reg_wdata_out (wdata)
    );
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, and a cycle ceiling that cuts a hang short
    always #20 clock_in = ~clock_in;
    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles == 14000)
        begin
            n_errors++;
            $display("[FAIL] %0t run timed out", $time);
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Bench reference check: serial, MSB first, bytes in ascending order
    function automatic logic [2:0] crc3(input logic [63:0] arr);
        logic [2:0] c;
        logic       fb;
        c = status_integrity_pkg::CRC_SEED;
        for (int i = 0; i < 64; i++)
        begin
            fb = c[2] ^ arr[8 * (i / 8) + 7 - (i % 8)];
            c = {c[1:0], 1'b0} ^ (fb ? 3'h3 : 3'h0);
        end
        return c;
    endfunction : crc3
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    // A missing answer reads as the inverse of the expected data, so it always shows as a mismatch
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        logic       ok;
        host.read_reg(a, d, ok);
        check(ok ? d : ~exp, exp, what);
    endtask : rd_chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : cyc
    task automatic do_reset();
        resetn_in = 1'b0;
        cyc(2);
        resetn_in = 1'b1;
    endtask : do_reset
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_init();
        rd_chk(ST, 8'h11, "status during init");
        rd_chk(ST, 8'h11, "init flag kept by read");
        cyc(INIT_W);
        rd_chk(ST, 8'h01, "init flag clears itself");
        rd_chk(ST, 8'h00, "reset flag cleared by read");
        rd_chk(8'h16, 8'h00, "correction x reset value");
        rd_chk(8'h17, 8'h00, "correction y reset value");
    endtask : t_init
    // All transient sources at once, then a lone second-axis event
    task automatic t_flags();
        {miso_mm, lim_x, lim_y, oth_fault} = 4'hf;
        cyc(1);
        {miso_mm, lim_x, lim_y, oth_fault} = 4'h0;
        host.write_zero(8'h1c);
        host.write_zero(ST);
        rd_chk(ST, 8'h4e, "transient flags set");
        rd_chk(ST, 8'h00, "transient flags cleared");
        lim_y = 1'b1;
        cyc(1);
        lim_y = 1'b0;
        rd_chk(ST, 8'h04, "second axis flag alone");
    endtask : t_flags
    task automatic t_corr();
        {cx, cy, cv_x, cv_y} = {8'h5a, 8'ha5, 2'h3};
        cyc(1);
        {cx, cv_x, cv_y} = {8'h80, 2'h0};
        rd_chk(8'h16, 8'h5a, "correction x");
        rd_chk(8'h17, 8'ha5, "correction y");
        cv_x = 1'b1;
        cyc(1);
        cv_x = 1'b0;
        rd_chk(8'h16, 8'h80, "latest correction x");
    endtask : t_corr
    // Any window of one prescaler period holds exactly one count step
    task automatic t_tick();
        logic [7:0] a;
        logic [7:0] b;
        logic       ok;
        time        t0;
        host.read_reg(8'h15, a, ok);
        t0 = host.take_t;
        for (int k = 1; k <= 3; k++)
        begin
            while ($time < t0 + k * status_integrity_pkg::PRESCALE_DIV * 40 - 80)
                @(posedge clock_in);
            host.read_reg(8'h15, b, ok);
            check(ok ? b - a : 8'h00, 8'h01, "count step per prescaler period");
            a = b;
        end
    endtask : t_tick
    task automatic t_crc();
        otp_crc = crc3(OTP_DATA) ^ 3'h1;
        cyc(3);
        rd_chk(ST, 8'h40, "fuse array fault");
        rd_chk(ST, 8'h40, "fuse fault set again");
        do_reset();
        cyc(INIT_W);
        rd_chk(ST, 8'h41, "fuse fault after reset");
        otp_crc = crc3(OTP_DATA);
        cyc(3);
        rd_chk(ST, 8'h40, "last fuse fault reported");
        rd_chk(ST, 8'h00, "good fuse check");
        wr_crc = crc3(WR_DATA) ^ 3'h4;
        cyc(3);
        rd_chk(ST, 8'h00, "writable check off");
        check({7'h00, lock}, 8'h00, "unlocked before end of init");
        eoi = 1'b1;
        cyc(3);
        check({7'h00, lock}, 8'h01, "locked at end of init");
        rd_chk(ST, 8'h40, "writable array fault");
        wr_crc = crc3(WR_DATA);
        cyc(3);
        rd_chk(ST, 8'h40, "writable fault sticks");
        eoi = 1'b0;
        do_reset();
        cyc(INIT_W);
        rd_chk(ST, 8'h01, "writable fault gone after reset");
    endtask : t_crc
    task automatic t_supply();
        logic [7:0] d;
        logic       ok;
        supply_ok = 1'b0;
        cyc(3);
        check({7'h00, in_rst}, 8'h01, "held while supply bad");
        host.read_reg(ST, d, ok);
        check({7'h00, ok}, 8'h00, "read answered in reset");
        supply_ok = 1'b1;
        cyc(INIT_W);
        check({7'h00, in_rst}, 8'h00, "out of reset");
        rd_chk(ST, 8'h01, "reset flag after supply reset");
    endtask : t_supply
    task automatic t_cap();
        logic [7:0] d;
        logic       ok;
        cap_fail = 1'b1;
        cyc(1);
        cap_fail = 1'b0;
        cyc(2);
        check({7'h00, fresp}, 8'h01, "fault response mode");
        host.read_reg(ST, d, ok);
        check({7'h00, d[0] & ok}, 8'h01, "reset flag after cap failure");
        {cap_hold, cap_fail} = 2'h3;
        cyc(1);
        cap_fail = 1'b0;
        cyc(10);
        check({7'h00, in_rst}, 8'h01, "held after cap failure");
        host.read_reg(ST, d, ok);
        check({7'h00, ok}, 8'h00, "read answered while held");
        cap_hold = 1'b0;
        do_reset();
        cyc(2);
        check({6'h00, in_rst, fresp}, 8'h00, "reset leaves hold");
    endtask : t_cap
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    // Main sequence: idle inputs, six-cycle reset, then each scenario
    initial
    begin
        {clock_in, resetn_in, supply_ok, cap_fail, cap_hold, miso_mm, lim_x, lim_y} = 8'h20;
        {oth_fault, cv_x, cv_y, eoi, cx, cy} = 20'h00000;
        otp_crc = crc3(OTP_DATA);
        wr_crc = crc3(WR_DATA);
        cyc(6);
        resetn_in = 1'b1;
        t_init();
        t_flags();
        t_corr();
        t_tick();
        t_crc();
        t_supply();
        t_cap();
        wrap_up();
    end
endmodule : status_integrity_registers_test
`default_nettype wire
